// ---- inc/serial_port_defs.svh ----
// Purpose: addresses, bit positions, reset values and counts of the serial port
// Assumes: one byte-wide special-function register port
// Notes:   definitions only
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
`define SFR_CONTROL_ADDR 8'h98
`define SFR_BUFFER_ADDR  8'h99
`define CTRL_RESET       8'h00
`define BUF_RESET        8'h00
`define READ_IDLE        8'h00
`define CTRL_MODE_HI     7
`define CTRL_MODE_LO     6
`define CTRL_MPF         5
`define CTRL_REN         4
`define CTRL_TB8         3
`define CTRL_RB8         2
`define CTRL_TI          1
`define CTRL_RI          0
`define TICK_LAST        4'hF
`define TICK_HALF        4'h7
`define BITS_EIGHT       4'h7
`define BITS_NINE        4'h8
`define M0_LAST_BIT      3'h7
`endif

// ---- inc/serial_port_pkg.sv ----
// Purpose: types shared by the serial port modules
// Assumes: constants live in serial_port_defs.svh
// Notes:   state codes are one-hot
package serial_port_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT       = 2'h0,
    MODE_UART8       = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR   = 2'h3
  } serial_mode_e;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_SHIFT = 4'h4,
    TX_STOP  = 4'h8
  } tx_state_e;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } sfr_req_s;
  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       stop;
  } rx_frame_s;
endpackage

// ---- logic/async_receiver.sv ----
// Purpose: asynchronous frame receiver, 16 ticks per bit
// Assumes: rxd_i already synchronised; tick_i is a one-cycle enable
// Notes:   dropping enable_i abandons a frame in progress
`timescale 1ns/10ps
`include "serial_port_defs.svh"
module async_receiver
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  // control
  input  wire logic  enable_i,
  input  wire logic  nine_i,
  input  wire logic  tick_i,
  input  wire logic  rxd_i,
  // result
  output logic       valid_o,
  output rx_frame_s  frame_o
);
  rx_state_e   state_reg;
  rx_state_e   state_next;
  logic [3:0]  tick_reg;
  logic [3:0]  bit_reg;
  logic [8:0]  shift_reg;
  logic        prev_reg;
  wire         fall      = prev_reg & ~rxd_i;
  wire         at_half   = tick_i && (tick_reg == `TICK_HALF);
  wire         at_full   = tick_i && (tick_reg == `TICK_LAST);
  wire  [3:0]  last_bit  = nine_i ? `BITS_NINE : `BITS_EIGHT;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RX_IDLE:  if (fall) state_next = RX_START;
      RX_START: if (at_half) state_next = rxd_i ? RX_IDLE : RX_DATA;
      RX_DATA:  if (at_full && bit_reg == last_bit) state_next = RX_STOP;
      RX_STOP:  if (at_full) state_next = RX_IDLE;
      default:  state_next = RX_IDLE;
    endcase
    if (!enable_i) state_next = RX_IDLE;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= RX_IDLE;
      tick_reg  <= 4'h0;
      bit_reg   <= 4'h0;
      shift_reg <= 9'h000;
      prev_reg  <= 1'b1;
      valid_o   <= 1'b0;
      frame_o   <= '0;
    end else begin
      prev_reg  <= rxd_i;
      state_reg <= state_next;
      valid_o   <= 1'b0;
      if (state_reg == RX_IDLE || (state_reg == RX_START && at_half)) begin
        tick_reg <= 4'h0;
        bit_reg  <= 4'h0;
      end else if (tick_i) begin
        tick_reg <= tick_reg + 4'h1;
      end
      if (state_reg == RX_DATA && at_full) begin
        shift_reg <= {rxd_i, shift_reg[8:1]};
        bit_reg   <= bit_reg + 4'h1;
      end
      // reported at the middle of the stop bit
      if (state_reg == RX_STOP && at_full && enable_i) begin
        valid_o       <= 1'b1;
        frame_o.data  <= nine_i ? shift_reg[7:0] : shift_reg[8:1];
        frame_o.ninth <= shift_reg[8];
        frame_o.stop  <= rxd_i;
      end
    end
  end
endmodule // async_receiver

// ---- logic/full_duplex_serial_port.sv ----
// Purpose: full-duplex serial port with buffered receiver, four modes
// Assumes: rate ticks are one-cycle pulses on clk_i at 16 per bit
// Notes:   mode 0 receive samples the pin two cycles late through the synchroniser
`timescale 1ns/10ps
`include "serial_port_defs.svh"
module full_duplex_serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // register port
  input  wire sfr_req_s   sfr_req_i,
  output logic [7:0]      sfr_rdata_o,
  // rate sources
  input  wire logic       rate_double_i,
  input  wire logic       tx_rate_tick_i,
  input  wire logic       rx_rate_tick_i,
  // serial pins
  input  wire logic       rxd_i,
  output logic            rxd_o,
  output logic            rxd_oe_o,
  output logic            txd_o,
  // status
  output logic            tx_busy_o
);
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  rx_buf_reg;
  tx_state_e   tx_state_reg;
  tx_state_e   tx_state_next;
  logic [8:0]  tx_shift_reg;
  logic [3:0]  tx_tick_reg;
  logic [3:0]  tx_bit_reg;
  logic        fixed_div_reg;
  logic        m0_active_reg;
  logic        m0_is_rx_reg;
  logic        m0_phase_reg;
  logic [2:0]  m0_bit_reg;
  logic [7:0]  m0_shift_reg;
  logic        txd_next;
  logic        rxd_sync;
  logic        frame_valid;
  rx_frame_s   frame;

  // register decode
  wire ctrl_wr = sfr_req_i.we && (sfr_req_i.addr == `SFR_CONTROL_ADDR);
  wire buf_wr  = sfr_req_i.we && (sfr_req_i.addr == `SFR_BUFFER_ADDR);
  wire ctrl_rd = sfr_req_i.re && (sfr_req_i.addr == `SFR_CONTROL_ADDR);
  wire buf_rd  = sfr_req_i.re && (sfr_req_i.addr == `SFR_BUFFER_ADDR);
  wire [7:0] rdata_next = ctrl_rd ? ctrl_reg :
                          buf_rd  ? rx_buf_reg : `READ_IDLE;

  // mode fields
  serial_mode_e mode;
  assign mode = serial_mode_e'(ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  wire is_shift = (mode == MODE_SHIFT);
  wire is_nine  = ctrl_reg[`CTRL_MODE_HI];
  wire mpf      = ctrl_reg[`CTRL_MPF];
  wire ren      = ctrl_reg[`CTRL_REN];
  wire tb8      = ctrl_reg[`CTRL_TB8];
  wire ri       = ctrl_reg[`CTRL_RI];

  // rate ticks: 16 per bit; mode 2 uses core/2 or core/1 ticks
  wire fixed_tick = rate_double_i | fixed_div_reg;
  wire tx_tick = (mode == MODE_UART9_FIXED) ? fixed_tick : tx_rate_tick_i;
  wire rx_tick = (mode == MODE_UART9_FIXED) ? fixed_tick : rx_rate_tick_i;

  // asynchronous transmitter
  wire tx_idle  = (tx_state_reg == TX_IDLE);
  wire tx_wrap  = tx_tick && (tx_tick_reg == `TICK_LAST);
  wire [3:0] tx_last = is_nine ? `BITS_NINE : `BITS_EIGHT;
  wire tx_launch = buf_wr && !is_shift && tx_idle;
  wire ti_async  = (tx_state_reg == TX_SHIFT) && (tx_state_next == TX_STOP);

  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      TX_IDLE:  if (tx_launch) tx_state_next = TX_START;
      TX_START: if (tx_wrap) tx_state_next = TX_SHIFT;
      TX_SHIFT: if (tx_wrap && tx_bit_reg == tx_last) tx_state_next = TX_STOP;
      TX_STOP:  if (tx_wrap) tx_state_next = TX_IDLE;
      default:  tx_state_next = TX_IDLE;
    endcase
  end

  // mode 0 shift engine
  wire m0_start_tx = buf_wr && is_shift && !m0_active_reg && tx_idle;
  wire m0_start_rx = is_shift && ren && !ri && !m0_active_reg && !buf_wr;
  wire m0_done = m0_active_reg && m0_phase_reg && (m0_bit_reg == `M0_LAST_BIT);
  wire [7:0] m0_next_shift = {rxd_sync, m0_shift_reg[7:1]};

  // receive acceptance and flags
  wire rb8_val   = (mode == MODE_UART8) ? frame.stop : frame.ninth;
  wire rx_accept = frame_valid && !is_shift && (!mpf || rb8_val);
  wire m0_rx_done = m0_done && m0_is_rx_reg;
  wire ri_set    = rx_accept || m0_rx_done;
  wire ti_set    = ti_async || (m0_done && !m0_is_rx_reg);

  // set beats a software clear in the same cycle
  always_comb begin
    ctrl_next = ctrl_wr ? sfr_req_i.wdata : ctrl_reg;
    if (ti_set) ctrl_next[`CTRL_TI] = 1'b1;
    if (ri_set) ctrl_next[`CTRL_RI] = 1'b1;
    if (rx_accept) ctrl_next[`CTRL_RB8] = rb8_val;
  end

  always_comb begin
    if (m0_active_reg) begin
      txd_next = m0_phase_reg;
    end else begin
      unique case (tx_state_reg)
        TX_START: txd_next = 1'b0;
        TX_SHIFT: txd_next = tx_shift_reg[0];
        default:  txd_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg    <= `CTRL_RESET;
      rx_buf_reg  <= `BUF_RESET;
      sfr_rdata_o <= `READ_IDLE;
    end else begin
      ctrl_reg <= ctrl_next;
      if (sfr_req_i.re) sfr_rdata_o <= rdata_next;
      if (rx_accept) rx_buf_reg <= frame.data;
      else if (m0_rx_done) rx_buf_reg <= m0_next_shift;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_state_reg  <= TX_IDLE;
      tx_shift_reg  <= 9'h1FF;
      tx_tick_reg   <= 4'h0;
      tx_bit_reg    <= 4'h0;
      fixed_div_reg <= 1'b0;
    end else begin
      fixed_div_reg <= ~fixed_div_reg;
      tx_state_reg  <= tx_state_next;
      if (tx_launch) begin
        tx_shift_reg <= {is_nine ? tb8 : 1'b1, sfr_req_i.wdata};
        tx_tick_reg  <= 4'h0;
        tx_bit_reg   <= 4'h0;
      end else if (tx_tick && !tx_idle) begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
      end
      if (tx_state_reg == TX_SHIFT && tx_wrap) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
      end
    end
  end

  // mode 0: one bit per two core cycles, clock low then high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      m0_active_reg <= 1'b0;
      m0_is_rx_reg  <= 1'b0;
      m0_phase_reg  <= 1'b0;
      m0_bit_reg    <= 3'h0;
      m0_shift_reg  <= 8'h00;
    end else if (!m0_active_reg) begin
      m0_phase_reg <= 1'b0;
      m0_bit_reg   <= 3'h0;
      if (m0_start_tx) begin
        m0_active_reg <= 1'b1;
        m0_is_rx_reg  <= 1'b0;
        m0_shift_reg  <= sfr_req_i.wdata;
      end else if (m0_start_rx) begin
        m0_active_reg <= 1'b1;
        m0_is_rx_reg  <= 1'b1;
      end
    end else begin
      m0_phase_reg <= ~m0_phase_reg;
      if (m0_phase_reg) begin
        m0_shift_reg <= m0_next_shift;
        m0_bit_reg   <= m0_bit_reg + 3'h1;
        if (m0_done) m0_active_reg <= 1'b0;
      end
    end
  end

  // pins, all from flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      txd_o     <= 1'b1;
      rxd_o     <= 1'b1;
      rxd_oe_o  <= 1'b0;
      tx_busy_o <= 1'b0;
    end else begin
      txd_o     <= txd_next;
      rxd_o     <= m0_shift_reg[0];
      rxd_oe_o  <= m0_active_reg && !m0_is_rx_reg;
      tx_busy_o <= !tx_idle || (m0_active_reg && !m0_is_rx_reg);
    end
  end

  line_sync u_rx_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (rxd_i),
    .q_o     (rxd_sync)
  );

  // receiver runs beside the transmitter
  async_receiver u_receiver (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .enable_i (ren && !is_shift),
    .nine_i   (is_nine),
    .tick_i   (rx_tick),
    .rxd_i    (rxd_sync),
    .valid_o  (frame_valid),
    .frame_o  (frame)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_ti_sticky: assert property (
    ctrl_reg[`CTRL_TI] && !ctrl_wr |=> ctrl_reg[`CTRL_TI])
    else $error("transmit done flag dropped by hardware");
  a_ri_sticky: assert property (
    ctrl_reg[`CTRL_RI] && !ctrl_wr |=> ctrl_reg[`CTRL_RI])
    else $error("receive done flag dropped by hardware");
  a_buf_read: assert property (
    buf_rd |=> sfr_rdata_o == $past(rx_buf_reg))
    else $error("buffer read did not return receive register");
  a_write_starts: assert property (
    buf_wr && !is_shift && tx_idle |=> tx_state_reg == TX_START ##1 !txd_o)
    else $error("buffer write did not start a frame");
  a_ti_at_stop: assert property (
    ti_async |=> ctrl_reg[`CTRL_TI] ##1 txd_o)
    else $error("transmit flag not set at stop bit");
  a_m0_rate: assert property (
    m0_active_reg && !m0_phase_reg |=> m0_phase_reg && m0_active_reg)
    else $error("mode 0 clock not at half core rate");
  a_rx_gated: assert property (
    !ren |=> !frame_valid)
    else $error("frame received while receiver disabled");
  a_mpf_ninth: assert property (
    frame_valid && is_nine && mpf && !frame.ninth && !ctrl_wr
    |=> ctrl_reg[`CTRL_RI] == $past(ctrl_reg[`CTRL_RI]))
    else $error("filtered frame raised receive flag");
  a_mpf_stop: assert property (
    frame_valid && mode == MODE_UART8 && mpf && !frame.stop
    |=> rx_buf_reg == $past(rx_buf_reg))
    else $error("frame with bad stop accepted under filter");
  a_overwrite: assert property (
    rx_accept |=> rx_buf_reg == $past(frame.data) && ctrl_reg[`CTRL_RI])
    else $error("accepted frame not placed in buffer");
  a_rb8_load: assert property (
    rx_accept |=> ctrl_reg[`CTRL_RB8] == $past(rb8_val))
    else $error("ninth bit not latched");

  a_ti_m0_end: assert property (
    m0_done && !m0_is_rx_reg |=> ctrl_reg[`CTRL_TI])
    else $error("mode 0 transmit flag not set after eighth bit");
  a_ri_m0_end: assert property (
    m0_rx_done |=> ctrl_reg[`CTRL_RI] && rx_buf_reg == $past(m0_next_shift))
    else $error("mode 0 receive did not complete");
  a_tx_ninth: assert property (
    tx_launch && is_nine |=> tx_shift_reg[8] == $past(tb8))
    else $error("ninth transmit bit not loaded from control");
  a_tx_stop_m1: assert property (
    tx_launch && !is_nine |=> tx_shift_reg[8])
    else $error("eight-bit frame not loaded with stop");
  a_m0_clock: assert property (
    m0_active_reg |=> txd_o == $past(m0_phase_reg))
    else $error("mode 0 shift clock wrong on transmit pin");
  a_m0_oe_off: assert property (
    !m0_active_reg |=> !rxd_oe_o)
    else $error("receive pin driven outside mode 0 transmit");
  a_m0_data: assert property (
    m0_active_reg && !m0_is_rx_reg |=> rxd_oe_o && rxd_o == $past(m0_shift_reg[0]))
    else $error("mode 0 data not on receive pin");
  a_m0_rx_gate: assert property (
    is_shift && !ren && !m0_active_reg && !buf_wr |=> !m0_active_reg)
    else $error("mode 0 started without enable or write");
  a_rx_off_shift: assert property (
    is_shift |=> !frame_valid)
    else $error("async frame reported in mode 0");
  a_m0_ends: assert property (
    m0_done |=> !m0_active_reg)
    else $error("mode 0 ran past eight bits");
  a_fixed_rate: assert property (
    mode == MODE_UART9_FIXED && !rate_double_i && !$past(rate_double_i) && !$past(reset_i)
    |-> tx_tick != $past(fixed_tick))
    else $error("mode 2 tick not every second cycle");
  a_rb8_uart8: assert property (
    rx_accept && mode == MODE_UART8 |=> ctrl_reg[`CTRL_RB8] == $past(frame.stop))
    else $error("stop bit not latched in mode 1");
  a_rb8_nine: assert property (
    rx_accept && is_nine |=> ctrl_reg[`CTRL_RB8] == $past(frame.ninth))
    else $error("received ninth bit not latched");
  a_mpf_off: assert property (
    frame_valid && !is_shift && !mpf |=> rx_buf_reg == $past(frame.data) && ctrl_reg[`CTRL_RI])
    else $error("unfiltered frame not accepted");
  a_txd_idle: assert property (
    tx_idle && !m0_active_reg |=> txd_o)
    else $error("transmit pin not idle high");
  a_ti_set_wins: assert property (
    ti_set |=> ctrl_reg[`CTRL_TI])
    else $error("transmit flag set lost");
  a_ri_set_wins: assert property (
    ri_set |=> ctrl_reg[`CTRL_RI])
    else $error("receive flag set lost");
  a_busy_rises: assert property (
    tx_launch |-> ##2 tx_busy_o)
    else $error("busy not shown after buffer write");

  c_m0_rx: cover property (m0_rx_done);
  c_tx_frame: cover property (ti_async ##[1:300] tx_idle);
  c_rx_accept: cover property (rx_accept);
  c_m0_tx: cover property (m0_done && !m0_is_rx_reg);
  c_overrun: cover property (rx_accept && ri);
endmodule // full_duplex_serial_port

// ---- logic/line_sync.sv ----
// Purpose: two-flop synchroniser for the receive pin
// Assumes: idle line level is high
// Notes:   first flop feeds only the second
`timescale 1ns/10ps
module line_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // line
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 1'b1;
      q_o      <= 1'b1;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // line_sync

// ---- verification/full_duplex_serial_port_tb_top.sv ----
// Purpose: self-checking bench for the serial port through its registers
// Assumes: rate ticks every second cycle, so 32 cycles per bit in modes 1, 3
// Notes:   shift-mode reception sees the idle-high line, so it must read FF
`timescale 1ns/10ps
`include "serial_port_defs.svh"
module full_duplex_serial_port_tb_top
  import serial_port_pkg::*;
;
  logic       clk;
  logic       reset;
  sfr_req_s   req;
  logic [7:0] rdata;
  logic       rate_double;
  logic       tick;
  logic       rxd_out;
  logic       rxd_oe;
  logic       txd;
  logic       busy;
  logic       drive;
  wire logic  pin_rxd;
  logic [7:0] bitc;
  logic       nine;
  logic       sync;
  logic [7:0] cap_data;
  logic       cap_ninth;
  logic       cap_stop;
  logic [7:0] frame_cnt;
  logic [7:0] low_run;
  logic [7:0] sync_data;
  logic [7:0] sync_period;
  logic [7:0] v;
  int         n_mismatch;
  int         comparisons;

  assign pin_rxd = rxd_oe ? rxd_out : drive;

  full_duplex_serial_port full_duplex_serial_port_inst (
    .clk_i(clk), .reset_i(reset), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .rate_double_i(rate_double), .tx_rate_tick_i(tick), .rx_rate_tick_i(tick),
    .rxd_i(pin_rxd), .rxd_o(rxd_out), .rxd_oe_o(rxd_oe), .txd_o(txd), .tx_busy_o(busy));

  remote_serial_node remote_serial_node_inst (
    .clk_i(clk), .bit_cycles_i(bitc), .nine_i(nine), .sync_mode_i(sync), .txd_i(txd),
    .line_i(pin_rxd), .drive_o(drive), .cap_data_o(cap_data), .cap_ninth_o(cap_ninth),
    .cap_stop_o(cap_stop), .frame_cnt_o(frame_cnt), .low_run_o(low_run),
    .sync_data_o(sync_data), .sync_period_o(sync_period));

  always #50 clk = ~clk;
  // external rate source: one tick every second cycle
  always @(negedge clk) tick <= reset ? 1'b0 : ~tick;

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout(input string what);
    n_mismatch++;
    $display("[ERR] %0t ns: gave up waiting for %s", $time, what);
    print_verdict();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(negedge clk);
    req.we = 1'b0;
  endtask

  // data answers one edge after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    req.re = 1'b1;
    @(negedge clk);
    req.re = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic wait_frames(input logic [7:0] n);
    for (int i = 0; i < 4000 && frame_cnt !== n; i++) @(negedge clk);
    if (frame_cnt !== n) timeout("captured frame");
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) timeout("idle transmitter");
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    req = '0;
    rate_double = 1'b0;
    tick = 1'b0;
    bitc = 8'd32;
    nine = 1'b0;
    sync = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk_rd(`SFR_CONTROL_ADDR, 8'h00);
    chk_rd(`SFR_BUFFER_ADDR, 8'h00);
    chk_rd(8'h9A, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(`SFR_CONTROL_ADDR, {m[1:0], 6'h00});
      chk_rd(`SFR_CONTROL_ADDR, {m[1:0], 6'h00});
    end
    $display("test registers done");

    wr(`SFR_CONTROL_ADDR, 8'h50);
    wr(`SFR_BUFFER_ADDR, 8'hA5);
    repeat (4) @(negedge clk);
    wr(`SFR_BUFFER_ADDR, 8'hFF);
    fork
      remote_serial_node_inst.send(8'h3C, 1'b0, 1'b1);
      begin
        wait_frames(8'd1);
        rd(`SFR_CONTROL_ADDR, v);
        check({7'h00, v[1]}, 8'h01);
        check({7'h00, busy}, 8'h01);
      end
    join
    check(cap_data, 8'hA5);
    check({7'h00, cap_stop}, 8'h01);
    repeat (400) @(negedge clk);
    check(frame_cnt, 8'd1);
    chk_rd(`SFR_CONTROL_ADDR, 8'h57);
    chk_rd(`SFR_BUFFER_ADDR, 8'h3C);
    $display("test duplex done");

    wr(`SFR_CONTROL_ADDR, 8'h50);
    remote_serial_node_inst.send(8'h11, 1'b0, 1'b1);
    remote_serial_node_inst.send(8'h22, 1'b0, 1'b1);
    chk_rd(`SFR_CONTROL_ADDR, 8'h55);
    chk_rd(`SFR_BUFFER_ADDR, 8'h22);
    wr(`SFR_CONTROL_ADDR, 8'h40);
    remote_serial_node_inst.send(8'h33, 1'b0, 1'b1);
    chk_rd(`SFR_CONTROL_ADDR, 8'h40);
    chk_rd(`SFR_BUFFER_ADDR, 8'h22);
    wr(`SFR_CONTROL_ADDR, 8'h70);
    remote_serial_node_inst.send(8'h44, 1'b0, 1'b0);
    chk_rd(`SFR_CONTROL_ADDR, 8'h70);
    remote_serial_node_inst.send(8'h55, 1'b0, 1'b1);
    chk_rd(`SFR_CONTROL_ADDR, 8'h75);
    chk_rd(`SFR_BUFFER_ADDR, 8'h55);
    $display("test receive done");

    nine = 1'b1;
    wr(`SFR_CONTROL_ADDR, 8'hF8);
    remote_serial_node_inst.send(8'h66, 1'b0, 1'b1);
    chk_rd(`SFR_CONTROL_ADDR, 8'hF8);
    remote_serial_node_inst.send(8'h77, 1'b1, 1'b1);
    chk_rd(`SFR_CONTROL_ADDR, 8'hFD);
    chk_rd(`SFR_BUFFER_ADDR, 8'h77);
    wr(`SFR_CONTROL_ADDR, 8'hF8);
    wr(`SFR_BUFFER_ADDR, 8'h5A);
    wait_frames(8'd2);
    wait_idle();
    check(cap_data, 8'h5A);
    check({7'h00, cap_ninth}, 8'h01);
    $display("test nine bit done");

    for (int d = 0; d < 2; d++) begin
      rate_double = d[0];
      bitc = d[0] ? 8'd16 : 8'd32;
      wr(`SFR_CONTROL_ADDR, 8'h80);
      wr(`SFR_BUFFER_ADDR, 8'hFF);
      wait_frames(8'd3 + d[7:0]);
      wait_idle();
      check(low_run, bitc);
      check(cap_data, 8'hFF);
      check({7'h00, cap_ninth}, 8'h00);
      chk_rd(`SFR_CONTROL_ADDR, 8'h82);
    end
    $display("test fixed rate done");

    sync = 1'b1;
    nine = 1'b0;
    wr(`SFR_CONTROL_ADDR, 8'h00);
    wr(`SFR_BUFFER_ADDR, 8'hC3);
    v = 8'h00;
    for (int i = 0; i < 200 && v[1] !== 1'b1; i++) rd(`SFR_CONTROL_ADDR, v);
    if (v[1] !== 1'b1) timeout("shift done flag");
    check(v, 8'h02);
    check(sync_data, 8'hC3);
    check(sync_period, 8'd2);
    wr(`SFR_CONTROL_ADDR, 8'h10);
    repeat (40) @(negedge clk);
    check({7'h00, rxd_oe}, 8'h00);
    chk_rd(`SFR_CONTROL_ADDR, 8'h11);
    chk_rd(`SFR_BUFFER_ADDR, 8'hFF);
    $display("test shift mode done");
    print_verdict();
  end
endmodule // full_duplex_serial_port_tb_top

// ---- verification/remote_serial_node.sv ----
// Purpose: remote node on the serial line; sends frames and captures ours
// Assumes: idle line is high; drives only off falling clock edges
// Notes:   bit length is given in core cycles by the bench
`timescale 1ns/10ps
module remote_serial_node (
  // clock
  input  wire logic       clk_i,
  // setup
  input  wire logic [7:0] bit_cycles_i,
  input  wire logic       nine_i,
  input  wire logic       sync_mode_i,
  // line
  input  wire logic       txd_i,
  input  wire logic       line_i,
  output logic            drive_o,
  // capture
  output logic [7:0]      cap_data_o,
  output logic            cap_ninth_o,
  output logic            cap_stop_o,
  output logic [7:0]      frame_cnt_o,
  output logic [7:0]      low_run_o,
  output logic [7:0]      sync_data_o,
  output logic [7:0]      sync_period_o
);
  logic [7:0]  run;
  logic [7:0]  cyc;
  logic        txd_q;
  logic [10:0] got;

  initial begin
    drive_o = 1'b1;
    frame_cnt_o = 8'h00;
    run = 8'h00;
    cyc = 8'h00;
  end

  // start 0, data lsb first, optional ninth, then stop
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
    logic [10:0] bits;
    bits = nine_i ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nine_i ? 11 : 10); i++) begin
      @(negedge clk_i);
      drive_o = bits[i];
      repeat (bit_cycles_i - 8'h01) @(negedge clk_i);
    end
    // one idle bit so a bad stop never runs into the next start
    @(negedge clk_i);
    drive_o = 1'b1;
    repeat (bit_cycles_i) @(negedge clk_i);
  endtask

  // samples mid-bit from the falling start edge; ends at mid-stop
  initial forever begin
    @(negedge txd_i);
    if (!sync_mode_i) begin
      repeat (bit_cycles_i / 8'h02) @(posedge clk_i);
      for (int i = 0; i < (nine_i ? 11 : 10); i++) begin
        if (i > 0) repeat (bit_cycles_i) @(posedge clk_i);
        got[i] = txd_i;
      end
      cap_data_o  = got[8:1];
      cap_ninth_o = nine_i ? got[9] : 1'b0;
      cap_stop_o  = nine_i ? got[10] : got[9];
      frame_cnt_o = frame_cnt_o + 8'h01;
    end
  end

  // low-run length and shift-clock data, rising clock edge only
  always @(posedge clk_i) begin
    txd_q <= txd_i;
    if (!sync_mode_i) begin
      if (!txd_i) begin
        run <= run + 8'h01;
      end else if (run != 8'h00) begin
        low_run_o <= run;
        run <= 8'h00;
      end
    end else if (txd_i && !txd_q) begin
      sync_data_o   <= {line_i, sync_data_o[7:1]};
      sync_period_o <= cyc;
      cyc <= 8'h01;
    end else begin
      cyc <= cyc + 8'h01;
    end
  end
endmodule // remote_serial_node
